// file: hw/rcp_ctrl.sv
// How it works
// (R1) free-run: output from local oscillator only
// (R2) locked: pick best input, lock to it
// (R3) holdover: oscillator held at last good frequency
// (R4) master and slave pick the same input
// (R5) loop cut-off programmable, 0.1 to 20 Hz
// (R6) system feeds a 12.80 MHz master clock
// (R7) each trim step adds 0.02 ppm
// (R8) trim resets to 39321, no correction
// (R9) trim is 16 bits in two bytes
// (R10) four reference inputs of any source type
// (R11) any port takes any reference type
// (R12) mode register bit 2: 1 SONET, 0 SDH
// (R13) rate bit seeded from pin at reset
// (R14) inputs to 100 MHz, listed spot frequencies
// (R15) default compare at the input frequency
// (R16) divide_to_8k_flag bit divides input to 8 kHz
// (R17) control bit picks 8 kHz locking edge
// (R18) divn bit routes input through N+1 divider
// (R19) each input enables divn on its own
// (R20) divide by N+1, 0 < N < 2^14-1
// (R21) software sets spot just below input
`timescale 1ns/1ps
`include "rcp_defines.svh"
module rcp_ctrl #(
	parameter int NREF = 4,
	parameter int NW = 14
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// reference pins and straps
	input wire logic [NREF-1:0] i_ref,
	input wire logic i_rate_pin,
	input wire logic i_mst_pin,
	// processor port
	input wire rcp_pkg::rcp_upi_in_t i_upi,
	output rcp_pkg::rcp_upi_out_t o_upi,
	// from quality monitors and partner unit
	input wire logic [NREF-1:0] i_ref_ok,
	input wire logic [1:0] i_partner_sel,
	// to the loop
	output rcp_pkg::rcp_mode_t o_mode,
	output logic [1:0] o_sel_ref,
	output logic o_dpll_evt,
	output logic o_freeze,
	output logic [15:0] o_trim,
	output logic [7:0] o_loop_bw,
	output logic o_sonet,
	output logic o_master
);
	import rcp_pkg::*;

	// register map and selection assume four inputs
	if (NREF != 4 || NW != 14) begin : g_chk
		$error("rcp_ctrl: NREF must be 4 and NW 14");
	end

	localparam int PW = $bits(rcp_upi_in_t) + 2;

	// true when the address hits a frequency setting slot
	function automatic logic freq_hit(input logic [6:0] a);
		return a[6:2] == `RCP_OFS_FREQ0 >> 2;
	endfunction

	// pin synchroniser stages and agreed levels
	logic [PW-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
	wire logic [PW-1:0] lvl_next;
	rcp_upi_in_t upi;
	wire logic rate_lvl, mst_lvl;

	// bus access state
	logic rd_reg, wr_reg;
	logic [7:0] rdata_reg;
	wire logic rd_act, wr_act, rd_go, wr_go;
	wire logic [6:0] a;
	wire logic [7:0] d;
	wire logic [7:0] rdata_next;

	// configuration registers
	logic [7:0] mode_reg, ctrl1_reg, opmode_reg, bw_reg;
	logic [15:0] trim_reg;
	logic [NW-1:0] divn_reg;
	rcp_freq_cfg_t freq_reg [NREF];
	wire logic [7:0] mode_seed;
	wire logic [NW-1:0] divn_cand;
	wire logic divn_ok;

	// mode control
	rcp_mode_t state_reg, state_next;
	logic [1:0] sel_reg, sel_next;
	logic dpll_evt_reg;
	wire logic auto_en, any_ok;
	wire logic [1:0] best, sel_src;
	wire logic [NREF-1:0] evt;

	// three flops on every pin; stage one feeds only stage two
	always_ff @(posedge i_clk) begin
		s1_reg <= {i_upi, i_rate_pin, i_mst_pin};
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
		lvl_reg <= lvl_next;
	end

	// per bit: follow stage three once two and three agree
	assign lvl_next = (s2_reg & s3_reg) | (lvl_reg & (s2_reg | s3_reg));
	assign upi = rcp_upi_in_t'(lvl_reg[PW-1:2]);
	assign rate_lvl = lvl_reg[1];
	assign mst_lvl = lvl_reg[0];

	// strobe decode; address and data have settled by now
	assign rd_act = ~upi.cs_n & ~upi.rd_n;
	assign wr_act = ~upi.cs_n & ~upi.wr_n;
	assign rd_go = rd_act & ~rd_reg;
	assign wr_go = wr_act & ~wr_reg;
	assign a = upi.addr;
	assign d = upi.data;

	// read mux; unmapped addresses read as zero
	assign rdata_next =
		freq_hit(a) ? 8'(freq_reg[a[1:0]]) :
		(a == `RCP_OFS_MODE) ? mode_reg :
		(a == `RCP_OFS_CTRL1) ? ctrl1_reg :
		(a == `RCP_OFS_OPMODE) ? opmode_reg :
		(a == `RCP_OFS_LOOPBW) ? bw_reg :
		(a == `RCP_OFS_STATUS) ? {state_reg, sel_reg, any_ok, 2'h0} :
		(a == `RCP_OFS_TRIM_LO) ? trim_reg[7:0] :
		(a == `RCP_OFS_TRIM_HI) ? trim_reg[15:8] :
		(a == `RCP_OFS_DIVN_LO) ? divn_reg[7:0] :
		(a == `RCP_OFS_DIVN_HI) ? {2'h0, divn_reg[13:8]} : 8'h00;

	// access tracking; read data captured at the strobe start
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rd_reg <= 1'b0;
			wr_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end else begin
			rd_reg <= rd_act;
			wr_reg <= wr_act;
			if (rd_go)
				rdata_reg <= rdata_next;
		end
	end

	// straps give the reset value of rate and master bits
	assign mode_seed = `RCP_MODE_RST
		| ({7'h00, rate_lvl} << `RCP_MODE_RATE_BIT)
		| ({7'h00, mst_lvl} << `RCP_MODE_MSTR_BIT); // R13

	// ratio of zero or all ones lies outside 0 < N < 2^14-1 and is refused
	assign divn_cand = (a == `RCP_OFS_DIVN_LO) ?
		{divn_reg[13:8], d} : {d[5:0], divn_reg[7:0]};
	assign divn_ok = (divn_cand != '0) &&
		(divn_cand < `RCP_DIVN_MAX); // R20

	// global configuration writes
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			mode_reg <= mode_seed; // R13
			ctrl1_reg <= `RCP_CTRL1_RST;
			opmode_reg <= `RCP_OPMODE_RST;
			bw_reg <= `RCP_BW_RST;
			trim_reg <= `RCP_TRIM_RST; // R8
			divn_reg <= `RCP_DIVN_RST;
		end else if (wr_go) begin
			if (a == `RCP_OFS_MODE)
				mode_reg <= d; // R12
			if (a == `RCP_OFS_CTRL1)
				ctrl1_reg <= d; // R17
			if (a == `RCP_OFS_OPMODE)
				opmode_reg <= d;
			if (a == `RCP_OFS_LOOPBW)
				bw_reg <= d; // R5
			if (a == `RCP_OFS_TRIM_LO)
				trim_reg[7:0] <= d; // R9
			if (a == `RCP_OFS_TRIM_HI)
				trim_reg[15:8] <= d; // R9
			if ((a == `RCP_OFS_DIVN_LO || a == `RCP_OFS_DIVN_HI)
				&& divn_ok)
				divn_reg <= divn_cand; // R20
		end
	end

	// one identical lane per reference input
	for (genvar i = 0; i < NREF; i++) begin : g_ref // R10 R11
		always_ff @(posedge i_clk) begin
			if (i_rst)
				freq_reg[i] <= rcp_freq_cfg_t'(`RCP_FREQ_RST);
			else if (wr_go && freq_hit(a) && a[1:0] == 2'(i))
				freq_reg[i] <= rcp_freq_cfg_t'(d); // R19
		end

		rcp_prediv #(
			.NW(NW)
		) u_prediv (
			.i_clk(i_clk),
			.i_rst(i_rst),
			.i_ref(i_ref[i]),
			.i_cfg(freq_reg[i]),
			.i_sonet(mode_reg[`RCP_MODE_RATE_BIT]),
			.i_fall(ctrl1_reg[`RCP_CTRL1_FALL_BIT]),
			.i_divn(divn_reg),
			.o_evt(evt[i])
		);
	end

	// lowest index among healthy inputs wins
	assign auto_en = opmode_reg[`RCP_OPMODE_AUTO_BIT];
	assign any_ok = |i_ref_ok;
	assign best = i_ref_ok[0] ? 2'd0 : i_ref_ok[1] ? 2'd1 :
		i_ref_ok[2] ? 2'd2 : 2'd3; // R2
	// a slave copies the master's choice to stay aligned
	assign sel_src = mode_reg[`RCP_MODE_MSTR_BIT] ?
		best : i_partner_sel; // R4

	// mode transitions
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			RCP_FREE: begin
				if (auto_en && any_ok)
					state_next = RCP_LOCK; // R2
			end
			RCP_LOCK: begin
				if (!auto_en)
					state_next = RCP_FREE; // R1
				else if (!any_ok)
					state_next = RCP_HOLD; // R3
			end
			RCP_HOLD: begin
				if (!auto_en)
					state_next = RCP_FREE; // R1
				else if (any_ok)
					state_next = RCP_LOCK; // R2
			end
			default: state_next = RCP_FREE;
		endcase
	end

	// selection only moves while locked; holdover keeps the last
	assign sel_next = (state_next == RCP_LOCK) ? sel_src : sel_reg; // R3

	// mode state and the phase event handed to the loop
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_reg <= RCP_FREE; // R1
			sel_reg <= 2'd0;
			dpll_evt_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			sel_reg <= sel_next;
			// no reference reaches the loop outside locked mode
			dpll_evt_reg <= (state_reg == RCP_LOCK) & evt[sel_reg]; // R15
		end
	end

	// outputs, all from registers
	assign o_mode = state_reg;
	assign o_sel_ref = sel_reg;
	assign o_dpll_evt = dpll_evt_reg;
	assign o_freeze = (state_reg == RCP_HOLD); // R3
	assign o_trim = trim_reg; // R7
	assign o_loop_bw = bw_reg; // R5
	assign o_sonet = mode_reg[`RCP_MODE_RATE_BIT]; // R12
	assign o_master = mode_reg[`RCP_MODE_MSTR_BIT];
	assign o_upi.data = rdata_reg;
	assign o_upi.oe = rd_reg;
	assign o_upi.rdy = rd_reg | wr_reg;

	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence s_write(logic [6:0] ofs);
		wr_go && a == ofs;
	endsequence

	sequence s_lock_req;
		state_reg == RCP_FREE && auto_en && any_ok;
	endsequence

	trim_reset_a: assert property ( // R8
		disable iff (1'b0) i_rst |=> trim_reg == `RCP_TRIM_RST)
		else $error("trim not at reset value");

	rate_seed_a: assert property ( // R13
		disable iff (1'b0) $fell(i_rst) |-> o_sonet == $past(rate_lvl))
		else $error("rate bit not seeded from pin");

	rate_write_a: assert property ( // R12
		s_write(`RCP_OFS_MODE) |=>
		o_sonet == $past(d[`RCP_MODE_RATE_BIT]))
		else $error("rate bit write lost");

	divn_range_a: assert property ( // R20
		divn_reg != '0 && divn_reg < `RCP_DIVN_MAX)
		else $error("divider ratio out of range");

	divn_refuse_a: assert property ( // R20
		(s_write(`RCP_OFS_DIVN_LO) or s_write(`RCP_OFS_DIVN_HI))
		##0 !divn_ok |=> $stable(divn_reg))
		else $error("illegal divider ratio taken");

	free_run_a: assert property ( // R1
		!auto_en |=> state_reg == RCP_FREE ##1 !o_dpll_evt)
		else $error("free-run not entered");

	lock_pick_a: assert property ( // R2
		s_lock_req ##0 o_master |=>
		state_reg == RCP_LOCK && o_sel_ref == $past(best))
		else $error("lock did not take best input");

	holdover_a: assert property ( // R3
		state_reg == RCP_LOCK && auto_en && !any_ok |=>
		o_freeze && $stable(o_sel_ref) ##1
		!o_dpll_evt)
		else $error("holdover not entered");

	slave_follow_a: assert property ( // R4
		state_reg == RCP_LOCK && auto_en && any_ok && !o_master |=>
		o_sel_ref == $past(i_partner_sel))
		else $error("slave did not follow partner");

	evt_pass_a: assert property ( // R15
		state_reg == RCP_LOCK && evt[sel_reg] |=> o_dpll_evt)
		else $error("phase event not passed on");

	read_ack_a: assert property (
		rd_go |=> o_upi.oe && o_upi.rdy && o_upi.data == $past(rdata_next))
		else $error("read not answered");
endmodule

// file: hw/rcp_defines.svh
`ifndef RCP_DEFINES_SVH
`define RCP_DEFINES_SVH
// register offsets on the processor port
`define RCP_OFS_FREQ0 7'h20
`define RCP_OFS_CTRL1 7'h30
`define RCP_OFS_OPMODE 7'h31
`define RCP_OFS_LOOPBW 7'h32
`define RCP_OFS_STATUS 7'h33
`define RCP_OFS_MODE 7'h34
`define RCP_OFS_TRIM_LO 7'h3C
`define RCP_OFS_TRIM_HI 7'h3D
`define RCP_OFS_DIVN_LO 7'h46
`define RCP_OFS_DIVN_HI 7'h47
// field positions
`define RCP_MODE_MSTR_BIT 1
`define RCP_MODE_RATE_BIT 2
`define RCP_CTRL1_FALL_BIT 0
`define RCP_OPMODE_AUTO_BIT 0
// reset values
`define RCP_MODE_RST 8'h00
`define RCP_FREQ_RST 8'h03
`define RCP_CTRL1_RST 8'h00
`define RCP_OPMODE_RST 8'h00
`define RCP_BW_RST 8'h00
`define RCP_TRIM_RST 16'h9999
`define RCP_DIVN_RST 14'h0001
`define RCP_DIVN_MAX 14'h3FFF
// spot frequency codes
`define RCP_SPOT_8K 4'h0
`define RCP_SPOT_T1E1 4'h1
`define RCP_SPOT_648 4'h2
`define RCP_SPOT_1944 4'h3
`define RCP_SPOT_2592 4'h4
`define RCP_SPOT_3888 4'h5
`define RCP_SPOT_5184 4'h6
`define RCP_SPOT_7776 4'h7
// edges per 8 kHz period, minus one
`define RCP_DIV_T1 14'h00C0
`define RCP_DIV_E1 14'h00FF
`define RCP_DIV_648 14'h0329
`define RCP_DIV_1944 14'h097D
`define RCP_DIV_2592 14'h0CA7
`define RCP_DIV_3888 14'h12FB
`define RCP_DIV_5184 14'h194F
`define RCP_DIV_7776 14'h25F7
`endif

// file: hw/rcp_pkg.sv
package rcp_pkg;
	// operating mode, one-hot
	typedef enum logic [2:0] {
		RCP_FREE = 3'b001,
		RCP_LOCK = 3'b010,
		RCP_HOLD = 3'b100
	} rcp_mode_t;
	// processor port pins into the device
	typedef struct packed {
		logic cs_n;
		logic wr_n;
		logic rd_n;
		logic [6:0] addr;
		logic [7:0] data;
	} rcp_upi_in_t;
	// processor port pins out of the device
	typedef struct packed {
		logic [7:0] data;
		logic oe;
		logic rdy;
	} rcp_upi_out_t;
	// per-input frequency setting
	typedef struct packed {
		logic divn;
		logic divide_to_8k_flag;
		logic [1:0] bucket;
		logic [3:0] spot;
	} rcp_freq_cfg_t;
endpackage

// file: hw/rcp_prediv.sv
`timescale 1ns/1ps
`include "rcp_defines.svh"
module rcp_prediv #(
	parameter int NW = 14
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// reference pin
	input wire logic i_ref,
	// configuration
	input wire rcp_pkg::rcp_freq_cfg_t i_cfg,
	input wire logic i_sonet,
	input wire logic i_fall,
	input wire logic [NW-1:0] i_divn,
	// phase comparison event
	output logic o_evt
);
	import rcp_pkg::*;

	// the 8 kHz ratio table needs the full divider width
	if (NW < 14) begin : g_chk
		$error("rcp_prediv: NW below 14");
	end

	// edges to count for one 8 kHz period, minus one
	function automatic logic [NW-1:0] spot_ratio(
		input logic [3:0] spot, input logic son);
		logic [13:0] r;
		r = '0;
		case (spot)
			`RCP_SPOT_T1E1: r = son ? `RCP_DIV_T1 : `RCP_DIV_E1;
			`RCP_SPOT_648: r = `RCP_DIV_648;
			`RCP_SPOT_1944: r = `RCP_DIV_1944;
			`RCP_SPOT_2592: r = `RCP_DIV_2592;
			`RCP_SPOT_3888: r = `RCP_DIV_3888;
			`RCP_SPOT_5184: r = `RCP_DIV_5184;
			`RCP_SPOT_7776: r = `RCP_DIV_7776;
			default: r = '0; // 8k and below pass as is
		endcase
		return NW'(r); // R14
	endfunction

	logic s1_reg, s2_reg, s3_reg, lvl_reg, evt_reg;
	logic [NW-1:0] cnt_reg;
	wire logic lvl_next, rise, fall, edge_hit, at_lim;
	wire logic [NW-1:0] limit;

	// three-stage pin synchroniser, free running
	always_ff @(posedge i_clk) begin
		s1_reg <= i_ref;
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
	end

	// a change counts once stages two and three agree
	assign lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
	assign rise = lvl_next & ~lvl_reg;
	assign fall = ~lvl_next & lvl_reg;
	// edge choice only matters while divide_to_8k_flag is set
	assign edge_hit = (i_cfg.divide_to_8k_flag & i_fall) ? fall : rise; // R17
	// divn overrides the table; zero limit is the direct path
	assign limit = i_cfg.divn ? i_divn : // R18 R20
		(i_cfg.divide_to_8k_flag ? spot_ratio(i_cfg.spot, i_sonet) : '0); // R15 R16
	assign at_lim = (cnt_reg >= limit);

	// count edges, one event per ratio+1 edges
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			lvl_reg <= 1'b0;
			cnt_reg <= '0;
			evt_reg <= 1'b0;
		end else begin
			lvl_reg <= lvl_next;
			evt_reg <= edge_hit & at_lim;
			if (edge_hit)
				cnt_reg <= at_lim ? '0 : NW'(cnt_reg + 1'b1);
		end
	end

	assign o_evt = evt_reg;
endmodule

// file: test/rcp_ref_src.sv
`timescale 1ns/1ps
// reference clock source on the far side of an input pin
module rcp_ref_src (
	// control
	input wire logic i_en,
	// reference pin and rising edge tally
	output logic o_ref,
	output int o_edges
);
	initial begin
		o_ref = 1'b0;
		o_edges = 0;
	end
	// 25 MHz square wave of one fixed type; stands low when off
	always begin
		#20;
		if (i_en) begin
			o_ref = !o_ref;
			if (o_ref)
				o_edges++;
		end else begin
			o_ref = 1'b0;
		end
	end
endmodule

// file: test/tb.sv
`timescale 1ns/1ps
`include "rcp_defines.svh"
module tb;
	import rcp_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic ref_en = 1'b0;
	logic [3:0] ref_ok = 4'h0;
	logic oe_q = 1'b0;
	rcp_upi_in_t upi = '{1'b1, 1'b1, 1'b1, 7'h00, 8'h00};
	rcp_upi_out_t o_upi;
	rcp_mode_t o_mode;
	logic [1:0] o_sel_ref;
	logic evt, o_freeze, o_sonet;
	logic [15:0] o_trim;
	logic [3:0] refs;
	logic [7:0] exq[$];
	int edges, last_e, prev_e, nev, n_errors, tests_run;
	logic [15:0] tv;
	logic [1:0] psel = 2'b00;
	logic [7:0] lbw;
	logic mst, lv0;
	logic lvl_e = 1'b0;
	wire ref_src;
	assign refs = {3'b000, ref_src};
	// stands in for the system master oscillator
	always #2.5 i_clk = !i_clk;
	rcp_ref_src src (.i_en(ref_en), .o_ref(ref_src), .o_edges(edges));
	rcp_ctrl uut (.i_clk(i_clk), .i_rst(i_rst), .i_ref(refs),
		.i_rate_pin(1'b1), .i_mst_pin(1'b1), .i_upi(upi), .o_upi(o_upi),
		.i_ref_ok(ref_ok), .i_partner_sel(psel), .o_mode(o_mode),
		.o_sel_ref(o_sel_ref), .o_dpll_evt(evt), .o_freeze(o_freeze),
		.o_trim(o_trim), .o_loop_bw(lbw), .o_sonet(o_sonet), .o_master(mst));
	task check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	task end_of_test;
		if (n_errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// one bus access: address first, strobe next edge, hold until rdy
	task acc(input logic w, input logic [6:0] a, input logic [7:0] d,
		input logic [7:0] exp);
		int n;
		@(posedge i_clk);
		upi <= '{1'b1, 1'b1, 1'b1, a, d};
		@(posedge i_clk);
		upi <= '{1'b0, !w, w, a, d};
		if (!w)
			exq.push_back(exp);
		for (n = 0; n < 40 && o_upi.rdy !== 1'b1; n++)
			@(posedge i_clk);
		if (n == 40)
			check(o_upi.rdy, 1'b1);
		upi <= '{1'b1, 1'b1, 1'b1, a, d};
		for (n = 0; n < 40 && o_upi.rdy !== 1'b0; n++)
			@(posedge i_clk);
		if (n == 40)
			check(o_upi.rdy, 1'b0);
		repeat (4) @(posedge i_clk);
	endtask
	// read results are judged against the oldest note
	always @(posedge i_clk) begin
		oe_q <= o_upi.oe;
		if (o_upi.oe === 1'b1 && oe_q !== 1'b1) begin
			if (exq.size() == 0)
				check(16'h0000, 16'hFFFF);
			else
				check({8'h00, o_upi.data}, {8'h00, exq.pop_front()});
		end
	end
	// ref edge count at each comparison event
	always @(posedge i_clk) begin
		if (evt === 1'b1) begin
			prev_e <= last_e;
			lvl_e <= ref_src;
			last_e <= edges;
			nev <= nev + 1;
		end
	end
	// spacing of comparison events in reference edges
	task gap(input int exp);
		int n, n0;
		@(posedge i_clk);
		n0 = nev;
		// nev has a single writer; count from where it stands now
		for (n = 0; n < 20000 && nev < n0 + 3; n++)
			@(posedge i_clk);
		if (n == 20000)
			check(16'(nev - n0), 16'h0003);
		check(16'(last_e - prev_e), 16'(exp));
	endtask
	initial begin
		repeat (60000) @(posedge i_clk);
		n_errors++;
		end_of_test;
	end
	initial begin
		void'($urandom(54));
		repeat (6) @(posedge i_clk);
		i_rst <= 1'b0;
		check(o_trim, 16'h9999);
		check(o_sonet, 1'b1);
		check(o_mode, RCP_FREE);
		acc(0, `RCP_OFS_TRIM_LO, 0, 8'h99);
		acc(0, `RCP_OFS_TRIM_HI, 0, 8'h99);
		acc(0, `RCP_OFS_MODE, 0, 8'h06);
		acc(0, `RCP_OFS_FREQ0, 0, 8'h03);
		acc(0, 7'h7F, 0, 8'h00);
		// random trim words, both bytes written, high byte read back
		repeat (3) begin
			tv = 16'($urandom());
			acc(1, `RCP_OFS_TRIM_LO, tv[7:0], 0);
			acc(1, `RCP_OFS_TRIM_HI, tv[15:8], 0);
			check(o_trim, tv);
			acc(0, `RCP_OFS_TRIM_HI, 0, tv[15:8]);
		end
		acc(1, `RCP_OFS_LOOPBW, tv[7:0], 0);
		check(lbw, tv[7:0]);
		acc(1, `RCP_OFS_MODE, 8'h02, 0);
		check(o_sonet, 1'b0);
		acc(1, `RCP_OFS_MODE, 8'h06, 0);
		check(o_sonet, 1'b1);
		// lock, lose every input, recover, read status
		acc(1, `RCP_OFS_OPMODE, 8'h01, 0);
		ref_ok <= 4'h1;
		repeat (3) @(posedge i_clk);
		check(o_mode, RCP_LOCK);
		check(o_sel_ref, 2'd0);
		ref_ok <= 4'h0;
		repeat (3) @(posedge i_clk);
		check(o_mode, RCP_HOLD);
		check(o_freeze, 1'b1);
		ref_ok <= 4'h1;
		repeat (3) @(posedge i_clk);
		check(o_mode, RCP_LOCK);
		acc(0, `RCP_OFS_STATUS, 0, 8'h44);
		// as a slave the choice comes from the partner
		psel <= 2'd2;
		acc(1, `RCP_OFS_MODE, 8'h04, 0);
		check(mst, 1'b0);
		check(o_sel_ref, 2'd2);
		acc(1, `RCP_OFS_MODE, 8'h06, 0);
		check(o_sel_ref, 2'd0);
		ref_en <= 1'b1;
		gap(1);
		// ratio 3, then a zero ratio that must be dropped
		acc(1, `RCP_OFS_DIVN_LO, 8'h03, 0);
		acc(1, `RCP_OFS_DIVN_LO, 8'h00, 0);
		acc(0, `RCP_OFS_DIVN_LO, 0, 8'h03);
		acc(1, `RCP_OFS_FREQ0, 8'h80, 0);
		gap(4);
		acc(1, `RCP_OFS_FREQ0, 8'h41, 0);
		gap(193);
		// pin level at the event shows which edge was counted
		lv0 = lvl_e;
		acc(1, `RCP_OFS_CTRL1, 8'h01, 0);
		gap(193);
		check(lvl_e, !lv0);
		acc(1, `RCP_OFS_OPMODE, 8'h00, 0);
		repeat (3) @(posedge i_clk);
		check(o_mode, RCP_FREE);
		check(16'(exq.size()), 16'h0000);
		end_of_test;
	end
endmodule
